// [rtl/cwod_decoder.v]
// Configuration word option decoder: holds the option word, decodes it
// into static settings and sequences power-up, start-up, sleep and watchdog.
// Assumes oscillator, watchdog RC and pins arrive asynchronous to MCLK_I;
// RST_N_I is the power-on reset of the whole part.
//
// Summary of operation
// - Programmed option bits read zero, unprogrammed read one; erased word is all ones.
// - The option word sits at one fixed address above user program space.
// - Test and option region is reachable only in programming mode.
// - Protect pair: 11 none, 10 upper range, 01 from middle up, 00 all.
// - External reset pin works when its enable bit is one.
// - Power-up delay bit is active low: zero enables the delay.
// - Watchdog enable bit one runs the watchdog, zero stops it.
// - Three select bits pick RC, internal RC, invalid or one of three crystals.
// - Software cannot stop the watchdog; only the option bit can.
// - Watchdog counts edges of its own RC oscillator only.
// - Enabled power-up delay holds reset a fixed 72 ms, on power-up or after programming mode only.
// - Start-up timer holds reset, or after a wake-up keeps the part asleep, until the crystal oscillator has settled.
// - Sleep ends on external reset, watchdog wake-up or enabled interrupt.
// - Crystal modes run a resonator across the two oscillator pins.
// - Crystal modes also accept an external clock on the clock input pin.
// - Clock-output modes drive the output pin at oscillator rate divided by four.
`timescale 1ns/1ps
`include "cwod_consts.vh"

module cwod_decoder #(
   parameter PUT_CYCLES = `CWOD_PUT_MS * `CWOD_CLK_KHZ,
   parameter [15:0] OST_EDGES = `CWOD_OST_EDGES,
   parameter [15:0] WDT_EDGES = `CWOD_WDT_EDGES
) (
   input wire MCLK_I,
   input wire RST_N_I,
   input wire PROG_MODE_I,
   input wire [13:0] PROG_ADDR_I,
   input wire [13:0] PROG_WDATA_I,
   input wire PROG_WR_I,
   input wire PROG_RD_I,
   output reg [13:0] PROG_RDATA_O,
   input wire EXT_RESET_PIN_N_I,
   input wire OSC_CLK_I,
   input wire WDT_OSC_I,
   input wire WDT_CLEAR_I,
   input wire SLEEP_REQ_I,
   input wire INT_WAKE_I,
   input wire [10:0] USER_ADDR_I,
   output wire ADDR_PROTECTED_O,
   output reg [1:0] PROTECT_MODE_O,
   output reg PROTECT_MISMATCH_O,
   output reg EXT_RESET_PIN_ENABLE_O,
   output reg POWERUP_DELAY_ENABLE_O,
   output reg WATCHDOG_ENABLE_O,
   output reg [2:0] OSC_MODE_O,
   output reg CRYSTAL_MODE_O,
   output reg OSC_INVALID_O,
   output reg CLOCK_OUTPUT_EN_O,
   output reg CLOCK_OUTPUT_O,
   output wire DEVICE_RESET_O,
   output wire SLEEP_O,
   output reg WAKE_O,
   output reg WDT_RESET_O
);

   // One-hot sequencer states
   localparam [4:0] ST_HOLD = 5'h01;
   localparam [4:0] ST_PUT = 5'h02;
   localparam [4:0] ST_OST = 5'h04;
   localparam [4:0] ST_RUN = 5'h08;
   localparam [4:0] ST_SLEEP = 5'h10;

   reg [13:0] option_word;
   reg [13:0] cfg_q;
   reg [4:0] state;
   reg [4:0] next_state;
   reg por_pend;
   reg waking;
   reg [21:0] put_cnt;
   reg [15:0] ost_cnt;
   reg [15:0] wdt_cnt;
   reg [1:0] clk_div;
   reg [1:0] pm_sync;
   reg [1:0] rst_sync;
   reg [2:0] osc_sync;
   reg [2:0] wdo_sync;
   wire prog_mode;
   wire ext_rst;
   wire osc_edge;
   wire wdo_edge;
   wire put_done;
   wire ost_done;
   wire wdt_tmo;
   wire xtal;
   wire cfg_hit;

   // Pins cross into the core clock through two flops before use
   always @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         pm_sync <= 2'h3; // Assume programming until seen, so no false release
         rst_sync <= 2'h3;
         osc_sync <= 3'h0;
         wdo_sync <= 3'h0;
      end else begin
         pm_sync <= {pm_sync[0], PROG_MODE_I};
         rst_sync <= {rst_sync[0], EXT_RESET_PIN_N_I};
         osc_sync <= {osc_sync[1:0], OSC_CLK_I};
         wdo_sync <= {wdo_sync[1:0], WDT_OSC_I};
      end
   end

   // Edge detectors read only the second and third stages
   assign prog_mode = pm_sync[1];
   assign osc_edge = osc_sync[1] & ~osc_sync[2];
   assign wdo_edge = wdo_sync[1] & ~wdo_sync[2];
   assign ext_rst = ~rst_sync[1] & cfg_q[`CWOD_B_EXT_RESET_PIN_ENABLE];
   assign cfg_hit = (PROG_ADDR_I == `CWOD_CFG_ADDR);

   // Option word store. Programming can only pull bits to zero, like a
   // fuse; power-on reset models a fresh erased part.
   always @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         option_word <= `CWOD_ERASED;
      end else if (prog_mode && PROG_WR_I && cfg_hit) begin
         option_word <= option_word & PROG_WDATA_I;
      end
   end

   // Read-back of the test region only while in programming mode;
   // other test addresses read zero, user-space addresses are not ours.
   always @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         PROG_RDATA_O <= 14'h0000;
      end else if (prog_mode && PROG_RD_I) begin
         PROG_RDATA_O <= cfg_hit ? option_word : 14'h0000;
      end else if (!prog_mode) begin
         PROG_RDATA_O <= 14'h0000;
      end
   end

   // Capture the word only while held in reset, so run-time changes
   // on the programming port can never disturb a running part
   always @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         cfg_q <= `CWOD_ERASED;
      end else if (state == ST_HOLD) begin
         cfg_q <= option_word;
      end
   end

   assign xtal = (cfg_q[`CWOD_B_OSC_HI:`CWOD_B_OSC_LO] <= `CWOD_OSC_HS);

   // Decoded settings, registered from the captured word
   always @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         PROTECT_MODE_O <= `CWOD_CP_NONE;
         PROTECT_MISMATCH_O <= 1'b0;
         EXT_RESET_PIN_ENABLE_O <= 1'b1;
         POWERUP_DELAY_ENABLE_O <= 1'b0;
         WATCHDOG_ENABLE_O <= 1'b1;
         OSC_MODE_O <= `CWOD_OSC_ERC_CLK;
         CRYSTAL_MODE_O <= 1'b0;
         OSC_INVALID_O <= 1'b0;
         CLOCK_OUTPUT_EN_O <= 1'b0;
      end else begin
         PROTECT_MODE_O <= cfg_q[`CWOD_B_CPA_HI:`CWOD_B_CPA_LO];
         // Unequal pairs give no guaranteed scheme; flag it for software
         PROTECT_MISMATCH_O <=
            (cfg_q[`CWOD_B_CPA_HI:`CWOD_B_CPA_LO] != cfg_q[`CWOD_B_CPB_HI:`CWOD_B_CPB_LO]) |
            (cfg_q[`CWOD_B_CPA_HI:`CWOD_B_CPA_LO] != cfg_q[`CWOD_B_CPC_HI:`CWOD_B_CPC_LO]) |
            (cfg_q[`CWOD_B_CPA_HI:`CWOD_B_CPA_LO] != cfg_q[`CWOD_B_CPD_HI:`CWOD_B_CPD_LO]);
         EXT_RESET_PIN_ENABLE_O <= cfg_q[`CWOD_B_EXT_RESET_PIN_ENABLE];
         POWERUP_DELAY_ENABLE_O <= ~cfg_q[`CWOD_B_POWERUP_DELAY_ENABLE_N];
         WATCHDOG_ENABLE_O <= cfg_q[`CWOD_B_WATCHDOG_ENABLE];
         OSC_MODE_O <= cfg_q[`CWOD_B_OSC_HI:`CWOD_B_OSC_LO];
         CRYSTAL_MODE_O <= xtal;
         OSC_INVALID_O <= (cfg_q[`CWOD_B_OSC_HI:`CWOD_B_OSC_LO] == `CWOD_OSC_INVALID);
         CLOCK_OUTPUT_EN_O <=
            (cfg_q[`CWOD_B_OSC_HI:`CWOD_B_OSC_LO] == `CWOD_OSC_ERC_CLK) |
            (cfg_q[`CWOD_B_OSC_HI:`CWOD_B_OSC_LO] == `CWOD_OSC_IRC_CLK);
      end
   end

   // Address check for the memory read-out path, from registered mode
   assign ADDR_PROTECTED_O =
      (PROTECT_MODE_O == `CWOD_CP_ALL) |
      ((PROTECT_MODE_O == `CWOD_CP_MID) &&
       (USER_ADDR_I >= `CWOD_MID_LO) && (USER_ADDR_I <= `CWOD_PROT_HI)) |
      ((PROTECT_MODE_O == `CWOD_CP_UPPER) &&
       (USER_ADDR_I >= `CWOD_UPPER_LO) && (USER_ADDR_I <= `CWOD_PROT_HI));

   // Clock output: toggle every second oscillator edge, giving a quarter
   // rate; held low outside clock-output modes and during reset
   always @(posedge MCLK_I) begin
      if (!RST_N_I || !CLOCK_OUTPUT_EN_O || DEVICE_RESET_O) begin
         clk_div <= 2'h0;
         CLOCK_OUTPUT_O <= 1'b0;
      end else if (osc_edge) begin
         if (clk_div[0] == `CWOD_CLOCK_OUTPUT_HALF) begin
            clk_div <= 2'h0;
            CLOCK_OUTPUT_O <= ~CLOCK_OUTPUT_O;
         end else begin
            clk_div <= clk_div + 2'h1;
         end
      end
   end

   // Power-up delay counter, counts core clocks only in its state
   always @(posedge MCLK_I) begin
      if (!RST_N_I || state != ST_PUT) begin
         put_cnt <= 22'h00_0000;
      end else if (!put_done) begin
         put_cnt <= put_cnt + 22'h00_0001;
      end
   end
   assign put_done = (put_cnt >= PUT_CYCLES[21:0] - 22'h00_0001);

   // Start-up timer counts real oscillator edges so it waits for the
   // crystal itself, not for a guessed time
   always @(posedge MCLK_I) begin
      if (!RST_N_I || state != ST_OST) begin
         ost_cnt <= 16'h0000;
      end else if (osc_edge && !ost_done) begin
         ost_cnt <= ost_cnt + 16'h0001;
      end
   end
   assign ost_done = (ost_cnt >= OST_EDGES);

   // Watchdog: no software disable input exists at all; clearing only
   // restarts the count. Also restarts on entry to sleep.
   always @(posedge MCLK_I) begin
      if (!RST_N_I || !cfg_q[`CWOD_B_WATCHDOG_ENABLE] || state == ST_HOLD || state == ST_PUT) begin
         wdt_cnt <= 16'h0000;
      end else if (WDT_CLEAR_I || wdt_tmo || (state == ST_RUN && SLEEP_REQ_I)) begin
         wdt_cnt <= 16'h0000;
      end else if (wdo_edge) begin
         wdt_cnt <= wdt_cnt + 16'h0001;
      end
   end
   assign wdt_tmo = (wdt_cnt >= WDT_EDGES);

   // Reset and sleep sequencer
   always @* begin
      next_state = state;
      case (state)
         ST_HOLD: begin
            if (!prog_mode && !ext_rst) begin
               if (por_pend && !cfg_q[`CWOD_B_POWERUP_DELAY_ENABLE_N]) begin
                  next_state = ST_PUT;
               end else begin
                  next_state = ST_OST;
               end
            end
         end
         ST_PUT: begin
            if (ext_rst || prog_mode) begin
               next_state = ST_HOLD;
            end else if (put_done) begin
               next_state = ST_OST;
            end
         end
         ST_OST: begin
            if (ext_rst || prog_mode) begin
               next_state = ST_HOLD;
            end else if (!xtal || ost_done) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (ext_rst || wdt_tmo || prog_mode) begin
               next_state = ST_HOLD;
            end else if (SLEEP_REQ_I) begin
               next_state = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (ext_rst || prog_mode) begin
               next_state = ST_HOLD;
            end else if (wdt_tmo || INT_WAKE_I) begin
               next_state = ST_OST;
            end
         end
         default: begin
            next_state = ST_HOLD;
         end
      endcase
   end

   // State, power-up marker and wake flag. The marker is set by power-on
   // and held set throughout programming mode, so the delay applies only after those.
   always @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         state <= ST_HOLD;
         por_pend <= 1'b1;
         waking <= 1'b0;
         WAKE_O <= 1'b0;
         WDT_RESET_O <= 1'b0;
      end else begin
         state <= next_state;
         WAKE_O <= (state == ST_SLEEP) && (next_state == ST_OST);
         WDT_RESET_O <= (state == ST_RUN) && wdt_tmo && !ext_rst && !prog_mode;
         if (prog_mode) begin
            por_pend <= 1'b1;
         end else if (state == ST_OST) begin
            por_pend <= 1'b0;
         end
         if (state == ST_SLEEP && next_state == ST_OST) begin
            waking <= 1'b1;
         end else if (state != ST_OST) begin
            waking <= 1'b0;
         end
      end
   end

   // A wake-up restart of the crystal stalls the core without a reset
   assign DEVICE_RESET_O = (state == ST_HOLD) | (state == ST_PUT) | ((state == ST_OST) & ~waking);
   assign SLEEP_O = (state == ST_SLEEP) | ((state == ST_OST) & waking);

endmodule // cwod_decoder

// [include/cwod_consts.vh]
// Constants for the configuration word option decoder.
// Assumes a 50 MHz core clock and a 14-bit program word.
`ifndef CWOD_CONSTS_VH
`define CWOD_CONSTS_VH

// Address map of the option word and the test region
`define CWOD_CFG_ADDR 14'h2007
`define CWOD_TEST_LO 14'h2000
`define CWOD_ERASED 14'h3FFF

// Field positions inside the option word
`define CWOD_B_CPA_HI 13
`define CWOD_B_CPA_LO 12
`define CWOD_B_CPB_HI 11
`define CWOD_B_CPB_LO 10
`define CWOD_B_CPC_HI 9
`define CWOD_B_CPC_LO 8
`define CWOD_B_EXT_RESET_PIN_ENABLE 7
`define CWOD_B_CPD_HI 6
`define CWOD_B_CPD_LO 5
`define CWOD_B_POWERUP_DELAY_ENABLE_N 4
`define CWOD_B_WATCHDOG_ENABLE 3
`define CWOD_B_OSC_HI 2
`define CWOD_B_OSC_LO 0

// Protection pair codes and user address bounds
`define CWOD_CP_NONE 2'h3
`define CWOD_CP_UPPER 2'h2
`define CWOD_CP_MID 2'h1
`define CWOD_CP_ALL 2'h0
`define CWOD_UPPER_LO 11'h400
`define CWOD_MID_LO 11'h200
`define CWOD_PROT_HI 11'h7FE

// Oscillator select codes
`define CWOD_OSC_ERC_CLK 3'h7
`define CWOD_OSC_ERC_IO 3'h6
`define CWOD_OSC_IRC_CLK 3'h5
`define CWOD_OSC_IRC_IO 3'h4
`define CWOD_OSC_INVALID 3'h3
`define CWOD_OSC_HS 3'h2

// Timing: power-up delay in ms, clock in kHz, count defaults
`define CWOD_PUT_MS 32'h0000_0048
`define CWOD_CLK_KHZ 32'h0000_C350
`define CWOD_OST_EDGES 16'h0400
`define CWOD_WDT_EDGES 16'h0100
`define CWOD_CLOCK_OUTPUT_HALF 1'h1

`endif

// [bench/cwod_properties.sv]
// Checker for the option decoder: decode flags, protection, steadiness, resets.
// Bound to the decoder top module; sees only its ports.
`timescale 1ns/1ps
module cwod_properties (
   input wire MCLK_I,
   input wire RST_N_I,
   input wire EXT_RESET_PIN_N_I,
   input wire [10:0] USER_ADDR_I,
   input wire ADDR_PROTECTED_O,
   input wire [1:0] PROTECT_MODE_O,
   input wire EXT_RESET_PIN_ENABLE_O,
   input wire WATCHDOG_ENABLE_O,
   input wire [2:0] OSC_MODE_O,
   input wire CRYSTAL_MODE_O,
   input wire OSC_INVALID_O,
   input wire CLOCK_OUTPUT_EN_O,
   input wire DEVICE_RESET_O,
   input wire WDT_RESET_O
);
   // One clock domain, so one clocking and one disable for all
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (!RST_N_I);
   osc_crystal_a: assert property (
      CRYSTAL_MODE_O == (OSC_MODE_O < 3'h3)) else $error("crystal flag wrong");
   osc_invalid_a: assert property (
      OSC_INVALID_O == (OSC_MODE_O == 3'h3)) else $error("invalid flag wrong");
   // Reset value pairs mode 7 with output off, so only judged once running
   clock_output_sel_a: assert property (
      !DEVICE_RESET_O |-> CLOCK_OUTPUT_EN_O == (OSC_MODE_O[2] & OSC_MODE_O[0]))
      else $error("clock output select wrong");
   prot_edge_a: assert property (
      PROTECT_MODE_O[1] == PROTECT_MODE_O[0] |-> ADDR_PROTECTED_O != PROTECT_MODE_O[0])
      else $error("all or none protection wrong");
   prot_range_a: assert property (
      ^PROTECT_MODE_O |-> ADDR_PROTECTED_O == (USER_ADDR_I <= 11'h7FE &&
      USER_ADDR_I >= (PROTECT_MODE_O[0] ? 11'h200 : 11'h400))) else $error("range wrong");
   cfg_steady_a: assert property (
      !DEVICE_RESET_O [*5] |-> $stable({PROTECT_MODE_O, OSC_MODE_O, WATCHDOG_ENABLE_O}))
      else $error("settings moved while running");
   wdt_off_a: assert property (
      !WATCHDOG_ENABLE_O |-> !WDT_RESET_O) else $error("watchdog fired while off");
   ext_reset_a: assert property (
      (EXT_RESET_PIN_ENABLE_O && !EXT_RESET_PIN_N_I) [*5] |-> DEVICE_RESET_O)
      else $error("reset pin ignored");
endmodule // cwod_properties

bind cwod_decoder cwod_properties u_props (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I),
   .EXT_RESET_PIN_N_I(EXT_RESET_PIN_N_I), .USER_ADDR_I(USER_ADDR_I),
   .ADDR_PROTECTED_O(ADDR_PROTECTED_O), .PROTECT_MODE_O(PROTECT_MODE_O),
   .EXT_RESET_PIN_ENABLE_O(EXT_RESET_PIN_ENABLE_O), .WATCHDOG_ENABLE_O(WATCHDOG_ENABLE_O),
   .OSC_MODE_O(OSC_MODE_O), .CRYSTAL_MODE_O(CRYSTAL_MODE_O), .OSC_INVALID_O(OSC_INVALID_O),
   .CLOCK_OUTPUT_EN_O(CLOCK_OUTPUT_EN_O), .DEVICE_RESET_O(DEVICE_RESET_O),
   .WDT_RESET_O(WDT_RESET_O));

// [bench/cwod_osc_model.sv]
// Far side model: external clock on the clock input pin and the
// watchdog's own RC oscillator. Assumes a 20 ns core clock beside it.
`timescale 1ns/1ps
module cwod_osc_model (
   input wire wdt_run_i,
   output reg osc_clk_o,
   output reg wdt_osc_o
);
   // 80 ns clock at a fixed phase to the core, so the divided output
   // spacing comes out exact in core cycles
   initial begin
      osc_clk_o = 1'h0;
      #7;
      forever #40 osc_clk_o = ~osc_clk_o;
   end
   // Watchdog RC stands low when not wanted, so no stray timeouts
   initial begin
      wdt_osc_o = 1'h0;
      forever #50 wdt_osc_o = wdt_run_i & ~wdt_osc_o;
   end
endmodule // cwod_osc_model

// [bench/tb_config_word_option_decoder.sv]
// Bench for the option decoder: one option word per case, programmed,
// read back, released, then decode, protection, sleep, pin and watchdog.
// Assumes the oscillator model beside it and the bound checker.
`timescale 1ns/1ps
module tb_config_word_option_decoder;
   reg mclk = 1'h0, rst_n = 1'h0, prog_mode = 1'h0, prog_wr = 1'h0, prog_rd = 1'h0;
   reg pin_n = 1'h1, sleep_req = 1'h0, int_wake = 1'h0, wdt_run = 1'h0, wdt_clr = 1'h0, e;
   reg [13:0] prog_addr = 14'h0000, prog_wdata = 14'h0000, w = 14'h0000;
   reg [10:0] user_addr = 11'h000;
   reg [10:0] adr [0:5] = '{11'h1FF, 11'h200, 11'h3FF, 11'h400, 11'h7FE, 11'h7FF};
   wire osc, wdt_osc, prot, mism, ext_en, put_en, wdt_en, xtal, inval, cko_en, cko;
   wire dev_rst, slp, wake, wdt_rst;
   wire [13:0] rdata;
   wire [1:0] pmode;
   wire [2:0] osc_mode;
   wire [3:0] mon = {cko, slp, wake, dev_rst};
   integer error_cnt = 0, samples_checked = 0, i, j, k, n;

   // Core clock, 20 ns
   always #10 mclk = ~mclk;

   cwod_osc_model u_osc (.wdt_run_i(wdt_run), .osc_clk_o(osc), .wdt_osc_o(wdt_osc));

   // Short counts keep each case to a few hundred cycles
   cwod_decoder #(.PUT_CYCLES(32'h0000_0032), .OST_EDGES(16'h0008), .WDT_EDGES(16'h0008))
   dut (.MCLK_I(mclk), .RST_N_I(rst_n), .PROG_MODE_I(prog_mode), .PROG_ADDR_I(prog_addr),
      .PROG_WDATA_I(prog_wdata), .PROG_WR_I(prog_wr), .PROG_RD_I(prog_rd),
      .PROG_RDATA_O(rdata), .EXT_RESET_PIN_N_I(pin_n), .OSC_CLK_I(osc),
      .WDT_OSC_I(wdt_osc), .WDT_CLEAR_I(wdt_clr), .SLEEP_REQ_I(sleep_req),
      .INT_WAKE_I(int_wake), .USER_ADDR_I(user_addr), .ADDR_PROTECTED_O(prot),
      .PROTECT_MODE_O(pmode), .PROTECT_MISMATCH_O(mism), .EXT_RESET_PIN_ENABLE_O(ext_en),
      .POWERUP_DELAY_ENABLE_O(put_en), .WATCHDOG_ENABLE_O(wdt_en), .OSC_MODE_O(osc_mode),
      .CRYSTAL_MODE_O(xtal), .OSC_INVALID_O(inval), .CLOCK_OUTPUT_EN_O(cko_en),
      .CLOCK_OUTPUT_O(cko), .DEVICE_RESET_O(dev_rst), .SLEEP_O(slp), .WAKE_O(wake),
      .WDT_RESET_O(wdt_rst));

   // Inputs always move 2 ns after a rising edge
   task tk(input integer c);
      repeat (c) @(posedge mclk);
      #2;
   endtask

   task chk(input [63:0] nm, input [13:0] x, input [13:0] g);
      samples_checked = samples_checked + 1;
      if (g !== x) begin
         error_cnt = error_cnt + 1;
         $display("[FAIL] %0s expected %h seen %h", nm, x, g);
      end
   endtask

   // One programmer access; read data lands one edge after the strobe
   task acc(input wr, input [13:0] a, input [13:0] d);
      prog_addr = a;
      prog_wdata = d;
      prog_wr = wr;
      prog_rd = !wr;
      tk(1);
      prog_wr = 1'h0;
      prog_rd = 1'h0;
      tk(1);
   endtask

   // Bounded wait for one watched output to reach a level
   task wt(input integer s, input v, input integer lim);
      k = 0;
      while (mon[s] !== v && k < lim) begin
         tk(1);
         k = k + 1;
      end
   endtask

   // Program one word, release the part and check all it selects
   task cfg;
      rst_n = 1'h0;
      prog_mode = 1'h1;
      tk(12);
      rst_n = 1'h1;
      tk(3);
      acc(1'h0, 14'h2007, w);
      chk("erased", 14'h3FFF, rdata);
      acc(1'h1, 14'h2007, w);
      acc(1'h0, 14'h2000, w);
      chk("test", 14'h0000, rdata);
      // Word read last, so the closed read must really clear it
      acc(1'h0, 14'h2007, w);
      chk("word", w, rdata);
      prog_mode = 1'h0;
      tk(4);
      acc(1'h0, 14'h2007, w);
      chk("closed", 14'h0000, rdata);
      wt(0, 1'h0, 400);
      chk("powerup_timer", !w[4], k >= 40);
      chk("ost", !w[4] || w[2:0] < 3'h3, k >= 16);
      chk("pmode", w[13:12], pmode);
      chk("mismatch", w[13:12] != w[11:10] || w[13:12] != w[9:8]
         || w[13:12] != w[6:5], mism);
      chk("exten", w[7], ext_en);
      chk("puten", !w[4], put_en);
      chk("wdten", w[3], wdt_en);
      chk("osc", w[2:0], osc_mode);
      chk("xtal", w[2:0] < 3'h3, xtal);
      chk("inval", w[2:0] == 3'h3, inval);
      chk("ckoen", w[2] & w[0], cko_en);
      for (j = 0; j < 6; j = j + 1) begin
         user_addr = adr[j];
         tk(1);
         e = w[13:12] == 2'h0 || (w[13:12] != 2'h3 && adr[j] <= 11'h7FE
            && adr[j] >= (w[12] ? 11'h200 : 11'h400));
         chk("protect", e, prot);
      end
      // Divide by four shows as a 16 core cycle output period
      if (w[2] & w[0]) begin
         wt(3, 1'h0, 99);
         wt(3, 1'h1, 99);
         wt(3, 1'h0, 99);
         n = k;
         wt(3, 1'h1, 99);
         chk("clock_output", 14'h0010, n + k);
      end
      sleep_req = 1'h1;
      tk(1);
      sleep_req = 1'h0;
      chk("sleep", 1'h1, slp);
      int_wake = 1'h1;
      tk(1);
      int_wake = 1'h0;
      wt(1, 1'h1, 9);
      chk("wake", 1'h1, wake);
      wt(2, 1'h0, 99);
      chk("resume", 1'h0, slp);
      pin_n = 1'h0;
      tk(6);
      chk("pin", w[7], dev_rst);
      pin_n = 1'h1;
      wt(0, 1'h0, 99);
      wdt_run = 1'h1;
      // Clearing faster than the count restarts it but never switches it off
      n = 0;
      for (j = 0; j < 100; j = j + 1) begin
         wdt_clr = (j % 4 == 0);
         tk(1);
         n = n + wdt_rst;
      end
      wdt_clr = 1'h0;
      chk("wdtclr", 14'h0000, n);
      n = 0;
      repeat (200) begin
         tk(1);
         n = n + wdt_rst;
      end
      wdt_run = 1'h0;
      chk("wdt", w[3], n != 0);
   endtask

   // Verdict, reached from the end of the cases or from the watchdog
   task stop_test;
      if (error_cnt == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Every select code, protect code and option bit, then one odd pair
   initial begin
      for (i = 0; i < 9; i = i + 1) begin
         w = {i[1:0], i[1:0], i[1:0], i[0], i[1:0], i[1], i[2], i[2:0]};
         if (i == 8)
            w = 14'h3F9F;
         cfg;
      end
      stop_test;
   end

   // Hang guard, over five times the expected run
   initial begin
      #400000;
      error_cnt = error_cnt + 1;
      stop_test;
   end
endmodule // tb_config_word_option_decoder
